// ==== rtl/fsp_defines.svh ====
// constants for the flash sector protection block
//
// Summary of operation
// RQ1 - erase whole array or one sector; program one byte per operation
// RQ2 - sector erase or program leaves every other sector untouched
// RQ3 - external tool mode: all sectors and option byte writable and erasable
// RQ4 - application mode: sector 0 locked against program and erase
// RQ5 - sectors 0 and 1 are 4 KB at top; sector 0 is F000h-FFFFh
// RQ6 - sector count follows flash size: 4K one, 8K two, above three
// RQ7 - read-out protection blocks external reads and all flash writes
// RQ8 - removing protection first erases the whole array automatically; a reset restores option byte FFh (unprotected) without erasing
// RQ9 - protection bit lives in the option byte
// RQ10 - link: reset, serial clock in, two-way data, select/program voltage
// RQ11 - once tool attached, clock and data pins lost to the application
// RQ12 - tool owns reset during a session; application makes none
// RQ13 - tool switches device into in-circuit communication mode first
// RQ14 - RAM loader code chooses bytes, addresses and download interface
// RQ15 - application mode runs a user bootloader held in sector 0
// RQ16 - access guard key sequence must precede every program or erase
// RQ17 - test mode executes user patterns downloaded into RAM
// RQ18 - requests at protected sectors or array are ignored
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
`define FSP_ADDR_W       16
`define FSP_SEC0_BASE    16'hF000
`define FSP_SEC1_BASE    16'hE000
`define FSP_SEC_SHIFT    12
`define FSP_SIZE_4K      17'h01000
`define FSP_SIZE_8K      17'h02000
`define FSP_ERASED       8'hFF
`define FSP_KEY1         8'h56
`define FSP_KEY2         8'hAE
`define FSP_OPT_PROT_BIT 0
`define FSP_OPT_RESET    8'hFF
`define FSP_CMD_PROG     2'h1
`define FSP_CMD_SECT     2'h2
`define FSP_CMD_MASS     2'h3
`define FSP_CMD_OPT      2'h0
`define FSP_OP_NS        1000
`define FSP_OP_CYC       ((`FSP_OP_NS + 19) / 20)
`endif

// ==== rtl/fsp_pkg.sv ====
// types for the flash sector protection block
`default_nettype none
package fsp_pkg;
  typedef enum logic [1:0] {
    FSP_MODE_TOOL,
    FSP_MODE_ICP,
    FSP_MODE_IAP,
    FSP_MODE_ICT
  } fsp_mode_type;
  typedef enum {
    FSP_IDLE,
    FSP_PROG,
    FSP_ERASE,
    FSP_DONE
  } fsp_state_type;
endpackage : fsp_pkg
`default_nettype wire

// ==== rtl/fsp_link_sync.sv ====
// two flop synchroniser with edge detect for the serial link
`default_nettype none
module fsp_link_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else if (en_i)
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign q_o    = s2_r;
  assign rise_o = s2_r & ~s3_r;
endmodule : fsp_link_sync
`default_nettype wire

// ==== rtl/fsp_flash_ctrl.sv ====
// flash access and sector protection controller
`include "fsp_defines.svh"
`default_nettype none
module fsp_flash_ctrl #(
  parameter int FLASH_BYTES = 16384,
  parameter int OP_CYC      = `FSP_OP_CYC
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   tool_attached_i,
  input  wire logic                   icc_mode_i,
  input  wire logic                   iap_mode_i,
  input  wire logic                   ict_mode_i,
  input  wire logic                   incircuit_serial_clock_pin_i,
  input  wire logic                   incircuit_serial_data_pin_i,
  output logic                        incircuit_serial_data_pin_o,
  output logic                        incircuit_serial_data_pin_oe_o,
  input  wire logic                   incircuit_select_program_voltage_i,
  input  wire logic                   app_clk_pin_i,
  input  wire logic                   app_data_pin_i,
  output logic                        app_clk_pin_o,
  output logic                        app_data_pin_o,
  input  wire logic                   req_i,
  input  wire logic [1:0]             cmd_i,
  input  wire logic [`FSP_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   guard_wr_i,
  input  wire logic [7:0]             guard_key_i,
  input  wire logic                   ext_read_i,
  input  wire logic [`FSP_ADDR_W-1:0] rd_addr_i,
  output logic      [7:0]             rdata_o,
  output logic                        busy_o,
  output logic                        done_o,
  output logic                        refused_o,
  output logic                        readout_protect_option_bit_o,
  output logic                        ram_exec_o,
  output fsp_pkg::fsp_mode_type       mode_o
);
  localparam int AW = $clog2(FLASH_BYTES);
  localparam logic [`FSP_ADDR_W-1:0] BASE = `FSP_ADDR_W'(17'h10000 - 17'(FLASH_BYTES));
  // ==========================================================
  // reset and pin synchronisation
  logic rst1_r;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst1_r <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst1_r <= 1'b1;
      rst_n  <= rst1_r;
    end
  end
  logic [2:0] pin_q;
  logic [2:0] pin_rise;
  fsp_link_sync #(.W(3)) u_sync (
    .clk_i  (ref_clk_i),
    .rst_n_i(rst_n),
    .en_i   (clk_en_i),
    .d_i    ({incircuit_select_program_voltage_i, incircuit_serial_data_pin_i,
              incircuit_serial_clock_pin_i}),
    .q_o    (pin_q),
    .rise_o (pin_rise)
  );
  // ==========================================================
  // mode selection
  fsp_pkg::fsp_mode_type mode;
  always_comb
  begin
    if (ict_mode_i && icc_mode_i)
      mode = fsp_pkg::FSP_MODE_ICT; // RQ17
    else if (icc_mode_i)
      mode = fsp_pkg::FSP_MODE_ICP; // RQ13
    else if (iap_mode_i)
      mode = fsp_pkg::FSP_MODE_IAP; // RQ15
    else
      mode = fsp_pkg::FSP_MODE_TOOL;
  end
  assign mode_o     = mode;
  assign ram_exec_o = (mode == fsp_pkg::FSP_MODE_ICT) || (mode == fsp_pkg::FSP_MODE_ICP); // RQ14 RQ17
  // pins handed to the tool while attached
  assign app_clk_pin_o  = tool_attached_i ? 1'b0 : app_clk_pin_i;  // RQ11
  assign app_data_pin_o = tool_attached_i ? 1'b0 : app_data_pin_i; // RQ11
  // ==========================================================
  // storage
  logic [7:0] mem_r [FLASH_BYTES];
  logic [7:0] opt_r;
  logic       prot;
  assign prot = ~opt_r[`FSP_OPT_PROT_BIT]; // RQ9
  assign readout_protect_option_bit_o = opt_r[`FSP_OPT_PROT_BIT];
  function automatic logic [1:0] sector_of(input logic [`FSP_ADDR_W-1:0] a);
    if (a >= `FSP_SEC0_BASE)
      sector_of = 2'd0; // RQ5
    else if (a >= `FSP_SEC1_BASE)
      sector_of = 2'd1;
    else
      sector_of = 2'd2;
  endfunction : sector_of
  function automatic logic in_array(input logic [`FSP_ADDR_W-1:0] a);
    in_array = (a >= BASE);
  endfunction : in_array
  // ==========================================================
  // access guard key sequence
  logic [1:0] guard_r;
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      guard_r <= 2'd0;
    else if (clk_en_i)
    begin
      if (req_i)
        guard_r <= 2'd0;
      else if (guard_wr_i)
        guard_r <= (guard_key_i == `FSP_KEY1) ? 2'd1 :
                   (guard_r == 2'd1 && guard_key_i == `FSP_KEY2) ? 2'd2 : 2'd0; // RQ16
    end
  end
  // ==========================================================
  // request acceptance
  logic allowed;
  logic [1:0] sec;
  assign sec = sector_of(addr_i);
  always_comb
  begin
    allowed = (guard_r == 2'd2); // RQ16
    if (cmd_i != `FSP_CMD_OPT && cmd_i != `FSP_CMD_MASS)
      allowed = allowed && in_array(addr_i); // RQ6
    if (mode == fsp_pkg::FSP_MODE_IAP)
    begin
      if (cmd_i == `FSP_CMD_MASS || cmd_i == `FSP_CMD_OPT)
        allowed = 1'b0; // RQ4
      else if (sec == 2'd0)
        allowed = 1'b0; // RQ4 RQ18
    end
    if (prot && cmd_i != `FSP_CMD_OPT)
      allowed = 1'b0; // RQ7 RQ18
  end
  fsp_pkg::fsp_state_type st_r;
  logic [31:0]            cnt_r;
  logic [1:0]             cmd_r;
  logic [`FSP_ADDR_W-1:0] addr_r;
  logic [7:0]             data_r;
  logic                   done_r;
  logic                   refused_r;
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r      <= fsp_pkg::FSP_IDLE;
      cnt_r     <= '0;
      cmd_r     <= 2'd0;
      addr_r    <= '0;
      data_r    <= 8'h00;
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      done_r    <= 1'b0;
      refused_r <= 1'b0;
      case (st_r)
        fsp_pkg::FSP_IDLE:
          if (req_i)
          begin
            if (allowed)
            begin
              cmd_r  <= cmd_i;
              addr_r <= addr_i;
              data_r <= wdata_i;
              cnt_r  <= 32'(OP_CYC);
              st_r   <= (cmd_i == `FSP_CMD_PROG) ? fsp_pkg::FSP_PROG : fsp_pkg::FSP_ERASE; // RQ1
            end
            else
              refused_r <= 1'b1; // RQ18
          end
        fsp_pkg::FSP_PROG, fsp_pkg::FSP_ERASE:
          if (cnt_r <= 32'd1)
            st_r <= fsp_pkg::FSP_DONE;
          else
            cnt_r <= cnt_r - 32'd1;
        fsp_pkg::FSP_DONE:
        begin
          done_r <= 1'b1;
          st_r   <= fsp_pkg::FSP_IDLE;
        end
        default:
          st_r <= fsp_pkg::FSP_IDLE;
      endcase
    end
  end
  // array contents, no reset on memory
  always_ff @(posedge ref_clk_i)
  begin
    if (clk_en_i && st_r == fsp_pkg::FSP_DONE)
    begin
      for (int i = 0; i < FLASH_BYTES; i++)
      begin
        if (cmd_r == `FSP_CMD_MASS)
          mem_r[i] <= `FSP_ERASED; // RQ1
        else if (cmd_r == `FSP_CMD_OPT && prot && opt_r[`FSP_OPT_PROT_BIT] != data_r[`FSP_OPT_PROT_BIT])
          mem_r[i] <= `FSP_ERASED; // RQ8
        else if (cmd_r == `FSP_CMD_SECT &&
                 sector_of(BASE + `FSP_ADDR_W'(i)) == sector_of(addr_r))
          mem_r[i] <= `FSP_ERASED; // RQ2
      end
      if (cmd_r == `FSP_CMD_PROG)
        mem_r[AW'(addr_r - BASE)] <= mem_r[AW'(addr_r - BASE)] & data_r; // RQ1 RQ2
    end
  end
  // option byte, written on the same edge that erases the array as protection clears
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      opt_r <= `FSP_OPT_RESET;
    else if (clk_en_i && st_r == fsp_pkg::FSP_DONE && cmd_r == `FSP_CMD_OPT)
      opt_r <= data_r; // RQ3 RQ8 RQ9
  end
  // ==========================================================
  // read path and serial data pin
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= 8'h00;
    else if (clk_en_i)
    begin
      if (ext_read_i && prot)
        rdata_o <= 8'h00; // RQ7
      else if (in_array(rd_addr_i))
        rdata_o <= mem_r[AW'(rd_addr_i - BASE)];
      else
        rdata_o <= `FSP_ERASED;
    end
  end
  logic [7:0] sh_r;
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sh_r <= 8'h00;
    else if (clk_en_i && pin_rise[0] && tool_attached_i)
      sh_r <= {sh_r[6:0], pin_q[1]}; // RQ10
  end
  assign incircuit_serial_data_pin_o    = prot ? 1'b0 : sh_r[7]; // RQ7
  assign incircuit_serial_data_pin_oe_o = tool_attached_i && icc_mode_i && pin_q[2]; // RQ10
  assign busy_o    = (st_r != fsp_pkg::FSP_IDLE);
  assign done_o    = done_r;
  assign refused_o = refused_r;
endmodule : fsp_flash_ctrl
`default_nettype wire

// ==== test/fsp_flash_ctrl_monitor.sv ====
// port checker for the flash access controller
`include "fsp_defines.svh"
`default_nettype none
module fsp_flash_ctrl_monitor #(
  parameter int OP_CYC      = 2,
  parameter int FLASH_BYTES = 16384
) (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        clk_en_i,
  input wire logic        tool_attached_i,
  input wire logic        icc_mode_i,
  input wire logic        iap_mode_i,
  input wire logic        req_i,
  input wire logic [1:0]  cmd_i,
  input wire logic [15:0] addr_i,
  input wire logic        ext_read_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        refused_o,
  input wire logic        readout_protect_option_bit_o,
  input wire logic        app_clk_pin_o,
  input wire logic        app_data_pin_o,
  input wire logic        incircuit_serial_data_pin_oe_o
);
  localparam int DONE_MAX = OP_CYC + 2;
  logic [1:0] up_cnt_r;
  // ==========================================================
  // request acceptance, read, completion and pin checks
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
    if (!reset_n_i)
      up_cnt_r <= 2'h0;
    else if (up_cnt_r != 2'h3)
      up_cnt_r <= up_cnt_r + 2'h1;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_take;
    req_i && clk_en_i && !busy_o && !done_o && !refused_o && up_cnt_r == 2'h3;
  endsequence
  sequence s_boot_hit;
    s_take ##0 (iap_mode_i && (cmd_i == `FSP_CMD_MASS || addr_i >= `FSP_SEC0_BASE));
  endsequence
  a_iap_boot_lock: assert property (s_boot_hit |=> refused_o && !done_o)
    else $error("boot sector request not refused");
  a_prot_blocks: assert property (s_take ##0 (!readout_protect_option_bit_o
    && cmd_i != `FSP_CMD_OPT) |=> refused_o) else $error("write while protected");
  a_below_array: assert property (s_take ##0 (cmd_i inside {`FSP_CMD_PROG, `FSP_CMD_SECT}
    && int'(addr_i) < 65536 - FLASH_BYTES) |=> refused_o) else $error("outside array");
  a_prot_read: assert property (ext_read_i && clk_en_i && !readout_protect_option_bit_o
    |=> rdata_o == 8'h00) else $error("protected read leaked data");
  a_done_bound: assert property ($rose(busy_o) |-> ##[1:DONE_MAX] done_o)
    else $error("operation did not finish");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_refuse_pulse: assert property (refused_o |=> !refused_o && !done_o)
    else $error("refusal not a single pulse");
  a_app_cut: assert property (tool_attached_i |-> !app_clk_pin_o && !app_data_pin_o)
    else $error("application pins live with tool");
  a_data_drive: assert property (incircuit_serial_data_pin_oe_o
    |-> tool_attached_i && icc_mode_i) else $error("data pin driven outside link mode");
endmodule : fsp_flash_ctrl_monitor
`default_nettype wire

// ==== test/fsp_tool_model.sv ====
// programming tool model on the in-circuit link
`default_nettype none
module fsp_tool_model (
  output logic     ser_clk_o,
  output logic     ser_data_o,
  output logic     sel_o,
  output logic     attach_o,
  output logic     icc_o,
  input wire logic line_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_r;
  // ==========================================================
  // link driving
  initial
  begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b1;
    sel_o = 1'b0;
    attach_o = 1'b0;
    icc_o = 1'b0;
    got_r = 8'h00;
  end
  // select low lets the tool drive data, high hands the data pin to the device
  task automatic plug(input logic on, input logic sel);
    attach_o = on;
    icc_o = on;
    sel_o = sel;
  endtask : plug
  // msb first, clock stands still between frames
  task automatic frame(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      ser_data_o = b[i];
      #80 ser_clk_o = 1'b1;
      got_r = {got_r[6:0], line_i};
      #80 ser_clk_o = 1'b0;
    end
    ser_data_o = ~b[0];
  endtask : frame
endmodule : fsp_tool_model
`default_nettype wire

// ==== test/tb_flash_sector_protection.sv ====
// self-checking bench for the flash access controller
`include "fsp_defines.svh"
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_flash_sector_protection;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] PG = `FSP_CMD_PROG, SE = `FSP_CMD_SECT, MA = `FSP_CMD_MASS;
  logic ref_clk_i, reset_n_i, clk_en_i, tool_attached_i, icc_mode_i, iap_mode_i;
  logic ict_mode_i, incircuit_serial_clock_pin_i, incircuit_serial_data_pin_i, ldat;
  logic incircuit_serial_data_pin_o, incircuit_serial_data_pin_oe_o, app_clk_pin_o;
  logic incircuit_select_program_voltage_i, app_clk_pin_i, app_data_pin_i, app_data_pin_o;
  logic req_i, guard_wr_i, ext_read_i, busy_o, done_o, refused_o, ram_exec_o;
  logic readout_protect_option_bit_o;
  logic [1:0]  cmd_i;
  logic [15:0] addr_i, rd_addr_i;
  logic [7:0]  wdata_i, guard_key_i, rdata_o;
  fsp_pkg::fsp_mode_type mode_o;
  int          err_total = 0;
  int          n_checks = 0;
  // ==========================================================
  // design and tool
  assign incircuit_serial_data_pin_i = incircuit_serial_data_pin_oe_o ?
    incircuit_serial_data_pin_o : ldat;
  fsp_flash_ctrl #(.OP_CYC(2)) dut (
    .ref_clk_i, .reset_n_i, .clk_en_i, .tool_attached_i, .icc_mode_i, .iap_mode_i, .ict_mode_i,
    .incircuit_serial_clock_pin_i, .incircuit_serial_data_pin_i, .incircuit_serial_data_pin_o,
    .incircuit_serial_data_pin_oe_o, .incircuit_select_program_voltage_i, .app_clk_pin_i,
    .app_data_pin_i, .app_clk_pin_o, .app_data_pin_o, .req_i, .cmd_i, .addr_i, .wdata_i,
    .guard_wr_i, .guard_key_i, .ext_read_i, .rd_addr_i, .rdata_o, .busy_o, .done_o, .refused_o,
    .readout_protect_option_bit_o, .ram_exec_o, .mode_o);
  fsp_tool_model tool (.ser_clk_o(incircuit_serial_clock_pin_i), .ser_data_o(ldat),
    .sel_o(incircuit_select_program_voltage_i), .attach_o(tool_attached_i),
    .icc_o(icc_mode_i), .line_i(incircuit_serial_data_pin_i));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(negedge ref_clk_i);
  endtask : tick
  // f[1] skips the keys, f[0] expects a refusal
  task automatic op(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] f);
    guard_wr_i = !f[1];
    guard_key_i = `FSP_KEY1;
    tick();
    guard_key_i = `FSP_KEY2;
    tick();
    guard_wr_i = 1'b0;
    {cmd_i, addr_i, wdata_i, req_i} = {c, a, d, 1'b1};
    tick();
    req_i = 1'b0;
    for (int k = 0; k < 20 && done_o !== 1'b1 && refused_o !== 1'b1; k++) tick();
    `CHK(refused_o, f[0])
    `CHK(done_o, !f[0])
    tick();
  endtask : op
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    ext_read_i = 1'b1;
    rd_addr_i = a;
    tick();
    ext_read_i = 1'b0;
    `CHK(rdata_o, e)
  endtask : rd
  // ==========================================================
  // scenarios
  task automatic t_prog();
    op(MA, 16'hC000, 8'h00, 2'h0);
    op(PG, 16'hF000, 8'hA5, 2'h0);
    op(PG, 16'hEFFF, 8'h5A, 2'h0);
    op(PG, 16'hD000, 8'h11, 2'h0);
    op(PG, 16'hF000, 8'h0F, 2'h0);
    rd(16'hF000, 8'h05);
    op(SE, 16'hE123, 8'h00, 2'h0);
    rd(16'hEFFF, 8'hFF);
    rd(16'hF000, 8'h05);
    op(SE, 16'hF800, 8'h00, 2'h0);
    rd(16'hF000, 8'hFF);
    rd(16'hD000, 8'h11);
  endtask : t_prog
  task automatic t_guard();
    op(PG, 16'hD001, 8'h00, 2'h3);
    rd(16'hD001, 8'hFF);
    op(PG, 16'hBFFF, 8'h00, 2'h1);
  endtask : t_guard
  task automatic t_iap();
    iap_mode_i = 1'b1;
    op(PG, 16'hF000, 8'h00, 2'h1);
    `CHK(mode_o, fsp_pkg::FSP_MODE_IAP)
    op(SE, 16'hF000, 8'h00, 2'h1);
    op(MA, 16'hC000, 8'h00, 2'h1);
    op(`FSP_CMD_OPT, 16'hFFFF, 8'hFE, 2'h1);
    op(PG, 16'hE001, 8'h3C, 2'h0);
    rd(16'hF000, 8'hFF);
    rd(16'hE001, 8'h3C);
    iap_mode_i = 1'b0;
  endtask : t_iap
  task automatic t_prot();
    op(`FSP_CMD_OPT, 16'hFFFF, 8'hFE, 2'h0);
    `CHK(readout_protect_option_bit_o, 1'b0)
    rd(16'hE001, 8'h00);
    op(PG, 16'hD002, 8'h00, 2'h1);
    op(`FSP_CMD_OPT, 16'hFFFF, 8'hFF, 2'h0);
    `CHK(readout_protect_option_bit_o, 1'b1)
    rd(16'hE001, 8'hFF);
  endtask : t_prot
  task automatic t_link();
    tool.plug(1'b1, 1'b0);
    tick(3);
    `CHK(app_clk_pin_o, 1'b0)
    `CHK(app_data_pin_o, 1'b0)
    `CHK(incircuit_serial_data_pin_oe_o, 1'b0)
    tool.frame(8'hC3);
    tool.plug(1'b1, 1'b1);
    tick(3);
    `CHK(incircuit_serial_data_pin_oe_o, 1'b1)
    `CHK(incircuit_serial_data_pin_o, 1'b1)
    `CHK(mode_o, fsp_pkg::FSP_MODE_ICP)
    `CHK(ram_exec_o, 1'b1)
    tool.frame(8'h00);
    `CHK(tool.got_r, 8'hC3)
    ict_mode_i = 1'b1;
    tick();
    `CHK(ram_exec_o, 1'b1)
    `CHK(mode_o, fsp_pkg::FSP_MODE_ICT)
    ict_mode_i = 1'b0;
    tool.plug(1'b0, 1'b0);
    tick(3);
    `CHK(app_clk_pin_o, 1'b1)
  endtask : t_link
  task automatic summarize();
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    {reset_n_i, req_i, guard_wr_i, ext_read_i, iap_mode_i, ict_mode_i} = 6'h00;
    {clk_en_i, app_clk_pin_i, app_data_pin_i} = 3'h7;
    {cmd_i, addr_i, rd_addr_i, wdata_i, guard_key_i} = 50'h0;
    tick(16);
    reset_n_i = 1'b1;
    tick(3);
    t_prog();
    t_guard();
    t_iap();
    t_prot();
    t_link();
    summarize();
  end
  initial
  begin
    #100us;
    err_total++;
    summarize();
  end
endmodule : tb_flash_sector_protection
bind fsp_flash_ctrl fsp_flash_ctrl_monitor #(.OP_CYC(OP_CYC), .FLASH_BYTES(FLASH_BYTES)) u_mon (
  .ref_clk_i, .reset_n_i, .clk_en_i, .tool_attached_i, .icc_mode_i, .iap_mode_i, .req_i,
  .cmd_i, .addr_i, .ext_read_i, .rdata_o, .busy_o, .done_o, .refused_o,
  .readout_protect_option_bit_o, .app_clk_pin_o, .app_data_pin_o,
  .incircuit_serial_data_pin_oe_o);
`default_nettype wire
